// ===== logic/mblc_pkg.sv
// Functional notes
// - System 8-bit: swap when selected bank odd
// - System 16-bit: swap on odd byte access
// - Local 8-bit swap enable per address parity
// - Local 8-bit swap direction per address parity
// - System: swap direction on selected read
// - Local low byte on even writes/reads
// - Local high byte on byte-high writes/reads
// - Transceiver enable only on selected reads
// - Hold acknowledge while pseudo-static refreshing
// - No refresh hold in optimized local mode
// - Delay write strobe leading edge
// - Poll interrupt copies bank ready level
// - Ready interrupt on EEPROM write completion
// - Board read clears pending ready interrupt
// - Active-low byte-high-enable selects odd byte
// - Acknowledge only after data placed/accepted
package mblc_pkg;
  localparam logic [1:0] WE_DELAY_CYC = 2'h1;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef struct packed {
    logic local_mode;
    logic byte_mode8;
    logic optimized;
    logic refresh_hold_en;
    logic we_delay_en;
  } mblc_cfg_t;

  typedef struct packed {
    logic addr0;
    logic rd;
    logic wr;
    logic board_selected;
    logic byte_high_enable_n;
    logic bank_a_selected;
    logic bank_b_selected;
    logic bank_a_odd_chip_sel;
    logic bank_b_odd_chip_sel;
  } mblc_cyc_t;

  typedef struct packed {
    logic swap_buffer_oe_n;
    logic swap_direction_n;
    logic local_lo_byte_en_n;
    logic local_hi_byte_en_n;
    logic xcvr_oe_n;
  } mblc_lane_t;
endpackage

// ===== logic/mblc_sync.sv
`timescale 1ns/1ps
module mblc_sync
  import mblc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic q_q;
  logic q_d;

  always_comb
  begin
    sh_d = {sh_q[1:0], d_i};
    // Change accepted only when stages two and three agree
    q_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : q_q;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sh_q <= SYNC_RST;
      q_q <= 1'b1;
    end
    else
    begin
      sh_q <= sh_d;
      q_q <= q_d;
    end
  end

  assign q_o = q_q;
endmodule

// ===== logic/mblc_top.sv
`timescale 1ns/1ps
module mblc_top
  import mblc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input mblc_pkg::mblc_cfg_t cfg_i,
  input mblc_pkg::mblc_cyc_t cyc_i,
  input wire logic mem_done_i,
  input wire logic bank_a_ready_i,
  input wire logic bank_b_ready_i,
  output mblc_pkg::mblc_lane_t lane_o,
  output logic xfer_ack_n_o,
  output logic mem_we_n_o,
  output logic poll_irq_o,
  output logic ready_irq_o
);
  import mblc_pkg::*;

  // Ready pins come from memory devices, not this clock
  logic rdy_a_s;
  logic rdy_b_s;

  mblc_sync u_sync_a (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(bank_a_ready_i),
    .q_o(rdy_a_s)
  );

  mblc_sync u_sync_b (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(bank_b_ready_i),
    .q_o(rdy_b_s)
  );

  mblc_lane_t lane_q;
  mblc_lane_t lane_d;
  logic ack_n_q;
  logic ack_n_d;
  logic we_n_q;
  logic we_n_d;
  logic [1:0] we_cnt_q;
  logic [1:0] we_cnt_d;
  logic poll_q;
  logic poll_d;
  logic rdy_irq_q;
  logic rdy_irq_d;
  logic bank_rdy_q;
  logic bank_rdy_d;
  logic rd_sel_q;
  logic rd_sel_d;

  logic x;
  logic y;
  logic a;
  logic r;
  logic b;
  logic h;
  logic sa;
  logic sb;
  logic ap;
  logic bp;
  logic bank_rdy;
  logic hold;
  logic rd_sel;

  always_comb
  begin
    x = cfg_i.local_mode;
    y = cfg_i.byte_mode8;
    a = cyc_i.addr0;
    r = cyc_i.rd;
    b = cyc_i.board_selected;
    h = cyc_i.byte_high_enable_n;
    sa = cyc_i.bank_a_selected;
    sb = cyc_i.bank_b_selected;
    ap = cyc_i.bank_a_odd_chip_sel;
    bp = cyc_i.bank_b_odd_chip_sel;
    rd_sel = r & b;
    // Outputs stay active low; registered to keep glitches off the pins
    lane_d.swap_buffer_oe_n = !(
      (!x & y & sa & ap) | (!x & y & sb & bp) |
      (!x & !y & h & a) |
      (x & y & !a & sa & ap) | (x & y & !a & sb & bp) |
      (x & y & a & sb & (!ap | !bp)));
    lane_d.swap_direction_n = !(
      (x & y & r & !a & sa & ap) | (x & y & r & !a & sb & bp) |
      (x & y & !r & a & sa & (!ap | !bp)) |
      (!x & rd_sel));
    lane_d.local_lo_byte_en_n = !((x & !a & !r) | (x & !a & rd_sel));
    lane_d.local_hi_byte_en_n = !((x & !h & !r) | (x & !h & rd_sel));
    lane_d.xcvr_oe_n = !rd_sel;
    bank_rdy = sa ? rdy_a_s : (sb ? rdy_b_s : 1'b1);
    // Refresh hold has no effect in optimized local mode
    hold = cfg_i.refresh_hold_en & !(x & cfg_i.optimized) & !bank_rdy;
    ack_n_d = !(b & (r | cyc_i.wr) & mem_done_i & !hold);
    // Write strobe held off one cycle so data settles first
    we_cnt_d = we_cnt_q;
    we_n_d = 1'b1;
    if (!(b & cyc_i.wr))
    begin
      we_cnt_d = 2'h0;
    end
    else if (cfg_i.we_delay_en & (we_cnt_q < WE_DELAY_CYC))
    begin
      we_cnt_d = we_cnt_q + 2'h1;
    end
    else
    begin
      we_n_d = 1'b0;
    end
    poll_d = bank_rdy;
    bank_rdy_d = bank_rdy;
    rd_sel_d = rd_sel;
    rdy_irq_d = rdy_irq_q;
    if (rd_sel & !rd_sel_q)
    begin
      rdy_irq_d = 1'b0;
    end
    if (bank_rdy & !bank_rdy_q)
    begin
      rdy_irq_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lane_q <= '1;
      ack_n_q <= 1'b1;
      we_n_q <= 1'b1;
      we_cnt_q <= 2'h0;
      poll_q <= 1'b1;
      rdy_irq_q <= 1'b0;
      bank_rdy_q <= 1'b1;
      rd_sel_q <= 1'b0;
    end
    else
    begin
      lane_q <= lane_d;
      ack_n_q <= ack_n_d;
      we_n_q <= we_n_d;
      we_cnt_q <= we_cnt_d;
      poll_q <= poll_d;
      rdy_irq_q <= rdy_irq_d;
      bank_rdy_q <= bank_rdy_d;
      rd_sel_q <= rd_sel_d;
    end
  end

  assign lane_o = lane_q;
  assign xfer_ack_n_o = ack_n_q;
  assign mem_we_n_o = we_n_q;
  assign poll_irq_o = poll_q;
  assign ready_irq_o = rdy_irq_q;

  oe_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !lane_o.xcvr_oe_n |-> $past(cyc_i.rd & cyc_i.board_selected))
    else $error("transceiver enabled outside selected read");
  // Lanes still show reset values on the first edge after release
  sys_dir_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) && $past(!cfg_i.local_mode & cyc_i.rd & cyc_i.board_selected)
    |-> !lane_o.swap_direction_n)
    else $error("system read without swap direction");
  sys16_swap_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) && $past(!cfg_i.local_mode & !cfg_i.byte_mode8 & cyc_i.byte_high_enable_n
      & cyc_i.addr0) |-> !lane_o.swap_buffer_oe_n)
    else $error("odd byte access without swap");
  lo_byte_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) && $past(cfg_i.local_mode & !cyc_i.addr0 & !cyc_i.rd)
    |-> !lane_o.local_lo_byte_en_n)
    else $error("even write without low byte enable");
  hold_ack_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $past(hold) |-> xfer_ack_n_o)
    else $error("acknowledge given during refresh");
  we_delay_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $fell(mem_we_n_o) && $past(cfg_i.we_delay_en) |-> $past(cyc_i.wr, 2))
    else $error("write strobe not delayed");
  rdy_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(bank_rdy) |=> ready_irq_o)
    else $error("ready interrupt missing");
  rd_clr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(rd_sel) && !$rose(bank_rdy) |=> !ready_irq_o)
    else $error("read did not clear interrupt");
endmodule

// ===== verification/mblc_mem_model.sv
`timescale 1ns/1ps
module mblc_mem_model
#(parameter int BUSY_CYC = 20)
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic req_i,
  input wire logic hold_i,
  input wire logic we_n_i,
  output logic done_o,
  output logic rdy_o
);
  int cnt_q;
  logic we_q;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= 0;
      we_q <= 1'h1;
    end
    else
    begin
      we_q <= we_n_i;
      if (we_q && !we_n_i)
        cnt_q <= BUSY_CYC;
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
    end
  end
  // Busy while programming or refreshing
  assign rdy_o = (cnt_q == 0) && !hold_i;
  assign done_o = req_i;
endmodule

// ===== verification/test_memory_board_byte_lane_control.sv
`timescale 1ns/1ps
module test_memory_board_byte_lane_control;
  import mblc_pkg::*;
  logic clk, rst_n, hold, stall, done, rdy, rdy_b, ack, we_n, poll, irq;
  mblc_cfg_t cfg;
  mblc_cyc_t y;
  mblc_lane_t lane;
  int err_count, n_checks;
  mblc_top mblc_top_inst (.sys_clk_i(clk), .arst_n_i(rst_n), .cfg_i(cfg), .cyc_i(y),
    .mem_done_i(done), .bank_a_ready_i(rdy), .bank_b_ready_i(rdy_b), .lane_o(lane),
    .xfer_ack_n_o(ack), .mem_we_n_o(we_n), .poll_irq_o(poll), .ready_irq_o(irq));
  mblc_mem_model mblc_mem_model_inst (.sys_clk_i(clk), .arst_n_i(rst_n),
    .req_i((y.rd | y.wr) & !stall), .hold_i(hold), .we_n_i(we_n), .done_o(done),
    .rdy_o(rdy));
  function automatic mblc_lane_t exp_lane(logic x, logic b);
    logic a, ab, sw, sd, xl, xh, oe;
    a = y.addr0;
    ab = y.bank_a_selected & y.bank_a_odd_chip_sel | y.bank_b_selected & y.bank_b_odd_chip_sel;
    sw = b & ab & (!x | !a) | !x & !b & y.byte_high_enable_n & a
      | x & b & a & y.bank_b_selected & !(y.bank_a_odd_chip_sel & y.bank_b_odd_chip_sel);
    sd = x & b & y.rd & !a & ab | !x & y.rd & y.board_selected
      | x & b & !y.rd & a & y.bank_a_selected & !(y.bank_a_odd_chip_sel & y.bank_b_odd_chip_sel);
    oe = y.rd & y.board_selected;
    // Local bus has one read/write line: not reading means writing
    xl = x & !a & (!y.rd | oe);
    xh = x & !y.byte_high_enable_n & (!y.rd | oe);
    return ~{sw, sd, xl, xh, oe};
  endfunction
  task automatic cmp(string nm, logic [4:0] e, logic [4:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial
  begin
    rst_n = 0;
    cfg = '0;
    y = '0;
    hold = 0;
    stall = 0;
    rdy_b = 1;
    repeat (16) @(posedge clk);
    step(1);
    rst_n = 1;
    step(1);
    cmp("irq", 0, irq);
    cmp("poll", 1, poll);
    // Every mode, width and select combination; read with write never both
    for (int i = 0; i < 2048; i++)
    begin
      {cfg.local_mode, cfg.byte_mode8, y} = i[10:0];
      y.wr = y.wr & !y.rd;
      step(1);
      cmp("lane", exp_lane(cfg.local_mode, cfg.byte_mode8), lane);
      cmp("ack", !(y.board_selected & (y.rd | y.wr)), ack);
      cmp("we", !(y.board_selected & y.wr), we_n);
    end
    cfg = '0;
    y = '0;
    step(40);
    y.bank_a_selected = 1;
    y.board_selected = 1;
    y.rd = 1;
    step(3);
    cmp("irq", 0, irq);
    y.rd = 0;
    cfg.we_delay_en = 1;
    y.wr = 1;
    step(1);
    cmp("we", 1, we_n);
    step(1);
    cmp("we", 0, we_n);
    y.wr = 0;
    step(8);
    cmp("poll", 0, poll);
    cmp("irq", 0, irq);
    step(30);
    cmp("poll", 1, poll);
    cmp("irq", 1, irq);
    y.rd = 1;
    step(3);
    cmp("irq", 0, irq);
    cfg.refresh_hold_en = 1;
    hold = 1;
    step(8);
    cmp("ack", 1, ack);
    cfg.local_mode = 1;
    cfg.optimized = 1;
    step(2);
    cmp("ack", 0, ack);
    cfg.optimized = 0;
    step(2);
    cmp("ack", 1, ack);
    hold = 0;
    step(7);
    cmp("ack", 0, ack);
    stall = 1;
    step(2);
    cmp("ack", 1, ack);
    // Bank B ready pin is driven by the bench, not the memory model; the write leaves it high
    y.rd = 0;
    y.bank_a_selected = 0;
    y.bank_b_selected = 1;
    y.wr = 1;
    step(2);
    y.wr = 0;
    step(24);
    cmp("poll", 1, poll);
    y.rd = 1;
    step(2);
    cmp("irq", 0, irq);
    rdy_b = 0;
    step(6);
    cmp("poll", 0, poll);
    rdy_b = 1;
    step(6);
    cmp("irq", 1, irq);
    cmp("poll", 1, poll);
    end_sim();
  end
endmodule
